/* File: core/dmau_pkg.sv */
// Package of constants, types and the register map for the data memory address unit.
// Contract
// - Control registers are decoded in the window ending at 0FF hex, apart from RAM.
// - Unimplemented control addresses may return any data; writes there do nothing defined.
// - Byte-wide user RAM of 330 bytes holds the stack area.
// - Call or interrupt entry pushes the return address before jumping.
// - Subroutine exit restores the program counter; interrupt exit also restores flags.
// - Stack pointer decrements after each save and increments before each restore.
// - Register addressing works on A, X, Y, carry or flag word without memory.
// - Immediate addressing uses the second instruction byte as the operand value.
// - Direct-page addressing places the one-byte operand in the selected page.
// - Absolute addressing takes second byte as low, third as high address.
// - X-indexed direct page without offset uses X as the page address.
// - Auto-increment form accesses the page location at X, then adds one to X.
// - Direct page plus X adds X to the operand within the page.
// - Direct page plus Y adds Y to the operand within the page.
// - Y-indexed absolute adds Y to the sixteen-bit operand address.
// - X-indexed indirect reads a pointer at operand plus X and next location.
// - Y-indexed indirect reads a pointer at operand and next, then adds Y.
// - Absolute indirect jump loads the program counter from the absolute address.
// - Direct-page flag clear selects page zero, set selects page one.
// - Stack pointer is eight bits, undefined after reset, loaded by software; the code resets it to zero.
package dmau_pkg;
	localparam int ram_bytes = 330;
	localparam logic [15:0] ctrl_lo = 16'h00c0;
	localparam logic [15:0] ctrl_hi = 16'h00ff;
	localparam logic [7:0] stack_page = 8'h01;
	localparam logic [7:0] one_byte = 8'h01;
	localparam logic [7:0] page_zero = 8'h00;
	localparam logic [7:0] page_one = 8'h01;
	localparam logic [7:0] junk_read = 8'h00;
	localparam logic [7:0] reg_p0_data = 8'hc0;
	localparam logic [7:0] reg_p0_dir = 8'hc1;
	localparam logic [7:0] reg_p1_data = 8'hc2;
	localparam logic [7:0] reg_p1_dir = 8'hc3;
	localparam logic [7:0] reg_irq_en_hi = 8'hce;
	localparam logic [7:0] reg_irq_rq_hi = 8'hcf;
	localparam logic [7:0] reg_tm0 = 8'hd0;
	localparam logic [7:0] reg_tm1 = 8'hd1;
	localparam logic [7:0] reg_standby = 8'hf0;
	localparam logic [7:0] reg_adc_mode = 8'hf4;
	localparam logic [7:0] reg_adc_result = 8'hf5;
	localparam logic [7:0] reg_key_lo = 8'hf6;
	localparam logic [7:0] reg_key_hi = 8'hf7;
	localparam logic [7:0] reg_pu0 = 8'hf8;
	localparam logic [7:0] reg_pu1 = 8'hf9;
	localparam logic [7:0] reg_pu2 = 8'hfa;
	localparam logic [7:0] reg_pu3 = 8'hfb;
	localparam logic [7:0] reg_pu4 = 8'hfc;
	localparam logic [7:0] rst_zero = 8'h00;
	localparam logic [7:0] rst_adc_mode = 8'h01;
	localparam logic [7:0] mask_pu4 = 8'h3f;
	typedef enum logic [3:0] {
		am_register, am_immediate, am_direct, am_absolute, am_x_direct, am_x_autoinc,
		am_dp_x, am_dp_y, am_abs_y, am_x_indirect, am_y_indirect, am_abs_indirect
	} addr_mode_e;
	typedef enum logic [2:0] {
		op_none, op_access, op_push, op_pop, op_call, op_subroutine_exit, op_interrupt_exit, op_jump_op
	} op_e;
	typedef enum logic [2:0] {sel_a, sel_x, sel_y, sel_carry, sel_flags} reg_sel_e;
	typedef struct packed {
		op_e op;
		addr_mode_e mode;
		logic write;
		logic [7:0] op_lo;
		logic [7:0] op_hi;
		logic [7:0] wdata;
		reg_sel_e reg_sel;
	} request_s;
	typedef struct packed {
		logic done;
		logic [7:0] rdata;
		logic [15:0] addr;
		logic [15:0] pc;
		logic pc_load;
		logic [7:0] flags;
		logic flags_load;
	} answer_s;
endpackage

/* File: core/dmau_byte_ram.sv */
// Byte-wide user RAM with synchronous write and combinational read.
`timescale 1ns/1ps
module dmau_byte_ram
	import dmau_pkg::*;
(
	input wire logic ref_clk,
	input wire logic we,
	input wire logic [8:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [8:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [ram_bytes];
	always_ff @(posedge ref_clk) begin
		if (we && (int'(waddr) < ram_bytes)) begin
			mem[waddr] <= wdata;
		end
	end
	// Reads above the RAM top return zero rather than an unbacked cell.
	assign rdata = (int'(raddr) < ram_bytes) ? mem[raddr] : 8'h00;
endmodule

/* File: core/dmau_core.sv */
// Data memory decode, stack handling and effective address generation.
`timescale 1ns/1ps
module dmau_core
	import dmau_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic req_valid,
	input request_s req,
	input wire logic [7:0] acc_in,
	input wire logic [7:0] x_in,
	input wire logic [7:0] y_in,
	input wire logic carry_in,
	input wire logic [7:0] processor_flag_word,
	input wire logic [15:0] return_pc,
	input wire logic [15:0] target_pc,
	input wire logic irq_entry,
	input wire logic sp_load,
	input wire logic [7:0] sp_value,
	input wire logic [7:0] adc_result_in,
	input wire logic [7:0] port0_pins,
	input wire logic [7:0] port1_pins,
	output answer_s ans,
	output logic [7:0] x_out,
	output logic x_load,
	output logic [7:0] stack_pointer,
	output logic [7:0] port0_dir,
	output logic [7:0] port1_dir,
	output logic [7:0] pullup0,
	output logic [7:0] adc_mode
);
	typedef enum {st_idle, st_ptr_lo, st_ptr_hi, st_data, st_push_hi, st_push_lo, st_push_psw,
		st_pop_psw, st_pop_lo, st_pop_hi} state_e;
	state_e state;
	request_s cur;
	logic [15:0] ptr;
	logic [15:0] ea;
	logic [15:0] pc_hold;
	logic push_psw;
	logic [7:0] page;
	logic [7:0] dp_sum;
	logic [7:0] idx_base;
	logic [15:0] next_ea;
	logic [15:0] mem_addr;
	logic mem_we;
	logic [7:0] mem_wdata;
	logic [7:0] ram_rdata;
	logic [7:0] ctrl_rdata;
	logic [7:0] rd_byte;
	logic in_ctrl;
	logic [8:0] ram_addr;
	logic [7:0] p0_data, p1_data, irq_en_hi, irq_rq_hi, tm0, tm1, standby, key_lo, key_hi;
	logic [7:0] pullup1, pullup2, pullup3, pullup4;
	logic [7:0] reg_val;
	logic [15:0] stack_addr;

	assign page = processor_flag_word[5] ? page_one : page_zero;
	assign idx_base = (req.mode == am_dp_y) ? y_in : x_in;
	assign dp_sum = req.op_lo + idx_base;

	// Effective address of the first memory access of a request.
	always_comb begin
		next_ea = {page, req.op_lo};
		unique case (req.mode)
			am_register, am_immediate: next_ea = 16'h0000;
			am_direct: next_ea = {page, req.op_lo};
			am_absolute: next_ea = {req.op_hi, req.op_lo};
			am_x_direct, am_x_autoinc: next_ea = {page, x_in};
			am_dp_x, am_dp_y: next_ea = {page, dp_sum};
			am_abs_y: next_ea = {req.op_hi, req.op_lo} + {8'h00, y_in};
			am_x_indirect: next_ea = {page, dp_sum};
			am_y_indirect: next_ea = {page, req.op_lo};
			am_abs_indirect: next_ea = {req.op_hi, req.op_lo};
			default: next_ea = {page, req.op_lo};
		endcase
	end

	always_comb begin
		reg_val = acc_in;
		unique case (req.reg_sel)
			sel_a: reg_val = acc_in;
			sel_x: reg_val = x_in;
			sel_y: reg_val = y_in;
			sel_carry: reg_val = {7'h00, carry_in};
			sel_flags: reg_val = processor_flag_word;
			default: reg_val = acc_in;
		endcase
	end

	// Push writes at the pointer itself; pop reads one above it.
	assign stack_addr = (state == st_pop_psw || state == st_pop_lo || state == st_pop_hi) ?
		{stack_page, stack_pointer + one_byte} : {stack_page, stack_pointer};

	always_comb begin
		mem_addr = ea;
		mem_we = 1'b0;
		mem_wdata = cur.wdata;
		unique case (state)
			st_ptr_lo: mem_addr = ea;
			st_ptr_hi: mem_addr = {ea[15:8], ea[7:0] + one_byte};
			st_data: begin
				mem_addr = ea;
				mem_we = cur.write;
			end
			st_push_hi: begin
				mem_addr = stack_addr;
				mem_we = 1'b1;
				mem_wdata = pc_hold[15:8];
			end
			st_push_lo: begin
				mem_addr = stack_addr;
				mem_we = 1'b1;
				mem_wdata = pc_hold[7:0];
			end
			st_push_psw: begin
				mem_addr = stack_addr;
				mem_we = 1'b1;
				mem_wdata = processor_flag_word;
			end
			st_pop_psw, st_pop_lo, st_pop_hi: mem_addr = stack_addr;
			default: mem_addr = ea;
		endcase
	end

	assign in_ctrl = (mem_addr >= ctrl_lo) && (mem_addr <= ctrl_hi);
	assign ram_addr = mem_addr[8:0];

	dmau_byte_ram u_ram (
		.ref_clk(ref_clk),
		.we(mem_we && !in_ctrl),
		.waddr(ram_addr),
		.wdata(mem_wdata),
		.raddr(ram_addr),
		.rdata(ram_rdata)
	);

	// Write-only registers read back as junk; software keeps them with byte writes only.
	always_comb begin
		unique case (mem_addr[7:0])
			reg_p0_data: ctrl_rdata = (p0_data & port0_dir) | (port0_pins & ~port0_dir);
			reg_p1_data: ctrl_rdata = (p1_data & port1_dir) | (port1_pins & ~port1_dir);
			reg_irq_en_hi: ctrl_rdata = irq_en_hi;
			reg_irq_rq_hi: ctrl_rdata = irq_rq_hi;
			reg_tm0: ctrl_rdata = tm0;
			reg_tm1: ctrl_rdata = tm1;
			reg_adc_mode: ctrl_rdata = adc_mode;
			reg_adc_result: ctrl_rdata = adc_result_in;
			default: ctrl_rdata = junk_read;
		endcase
	end
	assign rd_byte = in_ctrl ? ctrl_rdata : ram_rdata;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			p0_data <= rst_zero;
			p1_data <= rst_zero;
			port0_dir <= rst_zero;
			port1_dir <= rst_zero;
			irq_en_hi <= rst_zero;
			irq_rq_hi <= rst_zero;
			tm0 <= rst_zero;
			tm1 <= rst_zero;
			standby <= rst_zero;
			adc_mode <= rst_adc_mode;
			key_lo <= rst_zero;
			key_hi <= rst_zero;
			pullup0 <= rst_zero;
			pullup1 <= rst_zero;
			pullup2 <= rst_zero;
			pullup3 <= rst_zero;
			pullup4 <= rst_zero;
		end else if (mem_we && in_ctrl) begin
			unique case (mem_addr[7:0])
				reg_p0_data: p0_data <= mem_wdata;
				reg_p0_dir: port0_dir <= mem_wdata;
				reg_p1_data: p1_data <= mem_wdata;
				reg_p1_dir: port1_dir <= mem_wdata;
				reg_irq_en_hi: irq_en_hi <= mem_wdata;
				reg_irq_rq_hi: irq_rq_hi <= mem_wdata;
				reg_tm0: tm0 <= mem_wdata;
				reg_tm1: tm1 <= mem_wdata;
				reg_standby: standby <= mem_wdata;
				reg_adc_mode: adc_mode <= mem_wdata;
				reg_key_lo: key_lo <= mem_wdata;
				reg_key_hi: key_hi <= mem_wdata;
				reg_pu0: pullup0 <= mem_wdata;
				reg_pu1: pullup1 <= mem_wdata;
				reg_pu2: pullup2 <= mem_wdata;
				reg_pu3: pullup3 <= mem_wdata;
				reg_pu4: pullup4 <= mem_wdata & mask_pu4;
				default: ;
			endcase
		end
	end

	// Stack pointer has no hardware reset value in the device; zero is loaded only to keep it defined.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			stack_pointer <= rst_zero;
		end else if (sp_load && state == st_idle) begin
			stack_pointer <= sp_value;
		end else if (state == st_push_hi || state == st_push_lo || state == st_push_psw) begin
			stack_pointer <= stack_pointer - one_byte;
		end else if (state == st_pop_psw || state == st_pop_lo || state == st_pop_hi) begin
			stack_pointer <= stack_pointer + one_byte;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= st_idle;
			cur <= '0;
			ea <= 16'h0000;
			ptr <= 16'h0000;
			pc_hold <= 16'h0000;
			push_psw <= 1'b0;
			ans <= '0;
			x_out <= rst_zero;
			x_load <= 1'b0;
		end else begin
			ans.done <= 1'b0;
			ans.pc_load <= 1'b0;
			ans.flags_load <= 1'b0;
			x_load <= 1'b0;
			unique case (state)
				st_idle: begin
					if (req_valid) begin
						cur <= req;
						ea <= next_ea;
						pc_hold <= return_pc;
						push_psw <= irq_entry;
						unique case (req.op)
							op_none: state <= st_idle;
							op_call: state <= st_push_hi;
							op_subroutine_exit, op_interrupt_exit: state <= (req.op == op_interrupt_exit) ?
								st_pop_psw : st_pop_lo;
							op_push, op_pop: state <= st_idle;
							op_access, op_jump_op: begin
								if (req.mode == am_register || req.mode == am_immediate) begin
									ans.done <= 1'b1;
									ans.rdata <= (req.mode == am_immediate) ? req.op_lo : reg_val;
									ans.addr <= 16'h0000;
								end else if (req.mode == am_x_indirect || req.mode == am_y_indirect ||
									req.mode == am_abs_indirect) begin
									state <= st_ptr_lo;
								end else begin
									state <= st_data;
								end
							end
						endcase
					end
				end
				st_ptr_lo: begin
					ptr[7:0] <= rd_byte;
					state <= st_ptr_hi;
				end
				st_ptr_hi: begin
					if (cur.mode == am_abs_indirect) begin
						ans.pc <= {rd_byte, ptr[7:0]};
						ans.pc_load <= 1'b1;
						ans.done <= 1'b1;
						state <= st_idle;
					end else begin
						ea <= (cur.mode == am_y_indirect) ? {rd_byte, ptr[7:0]} + {8'h00, y_in} :
							{rd_byte, ptr[7:0]};
						state <= st_data;
					end
				end
				st_data: begin
					ans.done <= 1'b1;
					ans.rdata <= rd_byte;
					ans.addr <= ea;
					if (cur.mode == am_x_autoinc) begin
						x_out <= x_in + one_byte;
						x_load <= 1'b1;
					end
					state <= st_idle;
				end
				st_push_hi: state <= st_push_lo;
				st_push_lo: begin
					if (push_psw) begin
						state <= st_push_psw;
					end else begin
						ans.pc <= target_pc;
						ans.pc_load <= 1'b1;
						ans.done <= 1'b1;
						state <= st_idle;
					end
				end
				st_push_psw: begin
					ans.pc <= target_pc;
					ans.pc_load <= 1'b1;
					ans.done <= 1'b1;
					state <= st_idle;
				end
				st_pop_psw: begin
					ans.flags <= rd_byte;
					ans.flags_load <= 1'b1;
					state <= st_pop_lo;
				end
				st_pop_lo: begin
					pc_hold[7:0] <= rd_byte;
					state <= st_pop_hi;
				end
				st_pop_hi: begin
					ans.pc <= {rd_byte, pc_hold[7:0]};
					ans.pc_load <= 1'b1;
					ans.done <= 1'b1;
					state <= st_idle;
				end
			endcase
		end
	end

	sequence push_two_s;
		state == st_push_hi ##1 state == st_push_lo;
	endsequence

	stack_dec_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == st_push_hi) |=> stack_pointer == $past(stack_pointer) - one_byte)
		else $error("stack pointer not decremented after save");
	stack_inc_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == st_pop_lo) |=> stack_pointer == $past(stack_pointer) + one_byte)
		else $error("stack pointer not incremented on restore");
	call_push_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		push_two_s |-> ##[1:2] ans.pc_load)
		else $error("call did not jump after pushing return address");
	ret_flags_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == st_idle && req_valid && req.op == op_subroutine_exit) |=> (!ans.flags_load) [*4])
		else $error("subroutine exit touched flags");
	interrupt_exit_flags_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == st_idle && req_valid && req.op == op_interrupt_exit) |=> ##1 ans.flags_load)
		else $error("interrupt exit did not restore flags");
	imm_value_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == st_idle && req_valid && req.op == op_access && req.mode == am_immediate)
		|=> ans.done && ans.rdata == $past(req.op_lo))
		else $error("immediate operand wrong");
	page_sel_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == st_idle && req_valid && req.mode == am_dp_x) |=> ea[15:8] == $past(page))
		else $error("direct page high byte wrong");
	autoinc_x_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == st_data && cur.mode == am_x_autoinc) |=> x_load && x_out == $past(x_in) + one_byte)
		else $error("auto increment of X wrong");
	ctrl_decode_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(mem_we && mem_addr == {8'h00, reg_p0_dir}) |=> port0_dir == $past(mem_wdata))
		else $error("control register write lost");
endmodule

/* File: bench/dmau_pin_model.sv */
// Pin and converter model standing outside the data memory address unit.
`timescale 1ns/1ps
module dmau_pin_model
	import dmau_pkg::*;
#(
	parameter logic [7:0] conv_value = 8'h9c
)
(
	input wire logic ref_clk,
	input wire logic [7:0] pullup0,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] port0_pins,
	output logic [7:0] port1_pins,
	output logic [7:0] adc_result_in
);
	logic [7:0] drift = 8'h00;
	// A floating pin without its pull-up must never look steady, so it toggles each cycle.
	always @(posedge ref_clk) begin
		drift <= ~drift;
	end
	// A cleared pull-up bit enables the pull-up, so an undriven pin then reads high.
	assign port0_pins = (ext_en & ext_val) | (~ext_en & ~pullup0) | (~ext_en & pullup0 & drift);
	assign port1_pins = {ext_val[3:0], ext_val[7:4]};
	assign adc_result_in = conv_value;
endmodule

/* File: bench/data_memory_address_unit_tb.sv */
// Self-checking testbench for the data memory address unit.
`timescale 1ns/1ps
module data_memory_address_unit_tb
	import dmau_pkg::*;
;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic req_valid = 1'b0;
	request_s req = '0;
	reg_sel_e rsel = sel_a;
	logic [7:0] acc_in = 8'h00, x_in = 8'h00, y_in = 8'h00, pfw = 8'h00, sp_value = 8'h00;
	logic carry_in = 1'b0, irq_entry = 1'b0, sp_load = 1'b0;
	logic [15:0] return_pc = 16'h0000, target_pc = 16'h0000;
	logic [7:0] ext_en = 8'h00, ext_val = 8'h00;
	wire logic [7:0] adc_result_in, port0_pins, port1_pins;
	answer_s ans;
	logic [7:0] x_out, stack_pointer, port0_dir, port1_dir, pullup0, adc_mode;
	logic x_load, seen_pc, seen_fl, seen_x;
	int errors = 0, cmp_count = 0, cycles = 0;

	dmau_core dmau_core_inst (.ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid), .req(req),
		.acc_in(acc_in), .x_in(x_in), .y_in(y_in), .carry_in(carry_in), .processor_flag_word(pfw),
		.return_pc(return_pc), .target_pc(target_pc), .irq_entry(irq_entry), .sp_load(sp_load),
		.sp_value(sp_value), .adc_result_in(adc_result_in), .port0_pins(port0_pins),
		.port1_pins(port1_pins), .ans(ans), .x_out(x_out), .x_load(x_load),
		.stack_pointer(stack_pointer), .port0_dir(port0_dir), .port1_dir(port1_dir),
		.pullup0(pullup0), .adc_mode(adc_mode));
	dmau_pin_model dmau_pin_model_inst (.ref_clk(ref_clk), .pullup0(pullup0), .ext_en(ext_en),
		.ext_val(ext_val), .port0_pins(port0_pins), .port1_pins(port1_pins),
		.adc_result_in(adc_result_in));

	always #5 ref_clk = ~ref_clk;

	task automatic give_verdict;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// Entered and left at a falling edge; pulses are collected while the unit is busy.
	task automatic run(input op_e op, input addr_mode_e m, input logic w, input logic [7:0] lo,
		input logic [7:0] hi, input logic [7:0] wd);
		int n;
		n = 0;
		seen_pc = 1'b0;
		seen_fl = 1'b0;
		seen_x = 1'b0;
		req = '{op, m, w, lo, hi, wd, rsel};
		req_valid = 1'b1;
		@(negedge ref_clk);
		req_valid = 1'b0;
		while (ans.done !== 1'b1 && n < 20) begin
			seen_pc |= ans.pc_load;
			seen_fl |= ans.flags_load;
			seen_x |= x_load;
			n++;
			@(negedge ref_clk);
		end
		seen_pc |= ans.pc_load;
		seen_fl |= ans.flags_load;
		seen_x |= x_load;
		if (n == 20) begin
			errors++;
			$display("wrong value at %0t: no completion", $time);
		end
	endtask

	task automatic wr(input addr_mode_e m, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] wd);
		run(op_access, m, 1'b1, lo, hi, wd);
	endtask

	task automatic rd(input addr_mode_e m, input logic [7:0] lo, input logic [7:0] hi);
		run(op_access, m, 1'b0, lo, hi, 8'h00);
	endtask

	task automatic t_ctrl;
		chk(adc_mode, 8'h01, "converter mode reset");
		chk(port0_dir, 8'h00, "direction reset");
		rd(am_direct, reg_adc_mode, 8'h00);
		chk(ans.rdata, 8'h01, "converter mode read");
		rd(am_direct, reg_adc_result, 8'h00);
		chk(ans.rdata, 8'h9c, "converter result");
		wr(am_direct, reg_p0_dir, 8'h00, 8'h0f);
		chk(port0_dir, 8'h0f, "direction written");
		rd(am_direct, reg_p0_dir, 8'h00);
		chk(ans.rdata, 8'h00, "write-only readback");
		wr(am_direct, reg_p0_data, 8'h00, 8'ha5);
		ext_en = 8'hf0;
		ext_val = 8'h3c;
		rd(am_direct, reg_p0_data, 8'h00);
		chk(ans.rdata, 8'h35, "port mixed read");
		ext_en = 8'h00;
		rd(am_direct, reg_p0_data, 8'h00);
		chk(ans.rdata, 8'hf5, "port pulled up");
		wr(am_direct, reg_pu0, 8'h00, 8'hff);
		chk(pullup0, 8'hff, "pull-up written");
		wr(am_direct, reg_adc_mode, 8'h00, 8'h47);
		chk(adc_mode, 8'h47, "converter mode written");
		wr(am_direct, reg_p1_dir, 8'h00, 8'hf0);
		chk(port1_dir, 8'hf0, "port one direction written");
		wr(am_direct, reg_p1_data, 8'h00, 8'h5a);
		ext_val = 8'h3c;
		rd(am_direct, reg_p1_data, 8'h00);
		chk(ans.rdata, 8'h53, "port one mixed read");
		wr(am_direct, 8'he9, 8'h00, 8'h55);
		rd(am_direct, 8'he9, 8'h00);
		chk(ans.rdata, junk_read, "unmapped read");
	endtask

	task automatic t_page;
		wr(am_direct, 8'h35, 8'h00, 8'h11);
		pfw = 8'h20;
		wr(am_direct, 8'h35, 8'h00, 8'h22);
		rd(am_direct, 8'h35, 8'h00);
		chk(ans.rdata, 8'h22, "page one data");
		chk(ans.addr, 16'h0135, "page one address");
		pfw = 8'h00;
		rd(am_direct, 8'h35, 8'h00);
		chk(ans.rdata, 8'h11, "page zero data");
		chk(ans.addr, 16'h0035, "page zero address");
	endtask

	task automatic t_abs;
		wr(am_absolute, 8'h48, 8'h01, 8'h6e);
		rd(am_absolute, 8'h48, 8'h01);
		chk(ans.addr, 16'h0148, "absolute address");
		chk(ans.rdata, 8'h6e, "absolute data");
		y_in = 8'h40;
		rd(am_abs_y, 8'h08, 8'h01);
		chk(ans.addr, 16'h0148, "absolute plus y");
		chk(ans.rdata, 8'h6e, "absolute plus y data");
	endtask

	task automatic t_index;
		pfw = 8'h20;
		x_in = 8'hf8;
		wr(am_dp_x, 8'h20, 8'h00, 8'h77);
		chk(ans.addr, 16'h0118, "page plus x wraps");
		x_in = 8'h18;
		rd(am_x_direct, 8'h00, 8'h00);
		chk(ans.addr, 16'h0118, "x direct address");
		chk(ans.rdata, 8'h77, "x direct data");
		y_in = 8'h10;
		rd(am_dp_y, 8'h08, 8'h00);
		chk(ans.rdata, 8'h77, "page plus y data");
		rd(am_x_autoinc, 8'h00, 8'h00);
		chk(ans.rdata, 8'h77, "auto-increment data");
		chk({seen_x, x_out}, 9'h119, "auto-increment x");
		pfw = 8'h00;
	endtask

	task automatic t_indirect;
		wr(am_direct, 8'h35, 8'h00, 8'h48);
		wr(am_direct, 8'h36, 8'h00, 8'h01);
		x_in = 8'h10;
		rd(am_x_indirect, 8'h25, 8'h00);
		chk(ans.addr, 16'h0148, "x indirect address");
		chk(ans.rdata, 8'h6e, "x indirect data");
		wr(am_direct, 8'h25, 8'h00, 8'h08);
		wr(am_direct, 8'h26, 8'h00, 8'h01);
		y_in = 8'h40;
		rd(am_y_indirect, 8'h25, 8'h00);
		chk(ans.addr, 16'h0148, "y indirect address");
		chk(ans.rdata, 8'h6e, "y indirect data");
		wr(am_absolute, 8'h40, 8'h01, 8'h34);
		wr(am_absolute, 8'h41, 8'h01, 8'h12);
		run(op_jump_op, am_abs_indirect, 1'b0, 8'h40, 8'h01, 8'h00);
		chk({seen_pc, ans.pc}, 17'h1_1234, "indirect jump");
	endtask

	task automatic t_reg_imm;
		logic [7:0] want [5];
		want = '{8'ha1, 8'hb2, 8'hc3, 8'h01, 8'h85};
		run(op_access, am_immediate, 1'b0, 8'h35, 8'h00, 8'h00);
		chk(ans.rdata, 8'h35, "immediate value");
		acc_in = 8'ha1;
		x_in = 8'hb2;
		y_in = 8'hc3;
		carry_in = 1'b1;
		pfw = 8'h85;
		for (int i = 0; i < 5; i++) begin
			rsel = reg_sel_e'(i);
			run(op_access, am_register, 1'b0, 8'h00, 8'h00, 8'h00);
			chk(ans.rdata, want[i], "register operand");
		end
		rsel = sel_a;
	endtask

	task automatic t_stack;
		sp_value = 8'h40;
		sp_load = 1'b1;
		@(negedge ref_clk);
		sp_load = 1'b0;
		chk(stack_pointer, 8'h40, "stack pointer load");
		return_pc = 16'h2a5c;
		target_pc = 16'h0f35;
		run(op_call, am_absolute, 1'b0, 8'h00, 8'h00, 8'h00);
		chk({seen_pc, ans.pc}, 17'h1_0f35, "call target");
		chk(stack_pointer, 8'h3e, "call stack pointer");
		rd(am_absolute, 8'h40, 8'h01);
		chk(ans.rdata, 8'h2a, "pushed high");
		rd(am_absolute, 8'h3f, 8'h01);
		chk(ans.rdata, 8'h5c, "pushed low");
		run(op_subroutine_exit, am_register, 1'b0, 8'h00, 8'h00, 8'h00);
		chk({seen_fl, seen_pc, ans.pc}, 18'h1_2a5c, "subroutine exit");
		chk(stack_pointer, 8'h40, "exit stack pointer");
		irq_entry = 1'b1;
		pfw = 8'h83;
		run(op_call, am_absolute, 1'b0, 8'h00, 8'h00, 8'h00);
		irq_entry = 1'b0;
		chk(stack_pointer, 8'h3d, "entry stack pointer");
		rd(am_absolute, 8'h3e, 8'h01);
		chk(ans.rdata, 8'h83, "pushed flags");
		pfw = 8'h00;
		run(op_interrupt_exit, am_register, 1'b0, 8'h00, 8'h00, 8'h00);
		chk({seen_fl, ans.flags}, 9'h183, "flags restored");
		chk(ans.pc, 16'h2a5c, "interrupt exit pc");
		chk(stack_pointer, 8'h40, "interrupt exit stack");
	endtask

	// Empty, push and pop codes are swallowed: no answer, no stack move and no memory write.
	task automatic t_refused;
		for (int i = 0; i < 3; i++) begin
			req = '{(i == 0) ? op_none : (i == 1) ? op_push : op_pop, am_direct, 1'b1, 8'h35, 8'h00, 8'hee, sel_a};
			req_valid = 1'b1;
			repeat (3) begin
				@(negedge ref_clk);
				req_valid = 1'b0;
				chk(ans.done, 1'b0, "refused code answered");
			end
			chk(stack_pointer, 8'h40, "refused code moved stack");
		end
		rd(am_direct, 8'h35, 8'h00);
		chk(ans.rdata, 8'h48, "refused code wrote memory");
	endtask

	initial begin
		repeat (2) @(negedge ref_clk);
		nrst = 1'b1;
		t_ctrl();
		t_page();
		t_abs();
		t_index();
		t_indirect();
		t_reg_imm();
		t_stack();
		t_refused();
		give_verdict();
	end
endmodule
